//--- rtl/hpmc_consts.vh
// Register offsets, field positions and reset values of the port map block
`ifndef HPMC_CONSTS_VH
`define HPMC_CONSTS_VH
// Register indices, one aligned word each
`define HPMC_IDX_CBT           8'h08
`define HPMC_IDX_FIXED         8'h09
`define HPMC_IDX_SP_OFF        8'h0A
`define HPMC_IDX_BP_OFF        8'h0B
`define HPMC_IDX_REMAP         8'hFB
`define HPMC_IDX_STATUS        8'h10
// Byte addresses, four times the index
`define HPMC_OFF_CBT           12'h020
`define HPMC_OFF_FIXED         12'h024
`define HPMC_OFF_SP_OFF        12'h028
`define HPMC_OFF_BP_OFF        12'h02C
`define HPMC_OFF_REMAP         12'h3EC
`define HPMC_OFF_STATUS        12'h040
`define HPMC_CBT_STRING_BIT    0
`define HPMC_CBT_REMAP_BIT     3
`define HPMC_CBT_MASK          8'h09
`define HPMC_PORT_MASK         8'h06
`define HPMC_CBT_RST           8'h00
`define HPMC_FIXED_RST         8'h00
`define HPMC_SP_OFF_RST        8'h00
`define HPMC_BP_OFF_RST        8'h00
`define HPMC_REMAP_RST         8'h21
`endif

//--- rtl/hpmc_port_numbering.v
// Port number assignment for the two downstream ports
`timescale 1ns/1ps
module hpmc_port_numbering (
	input  wire       remap_mode,     // Remap mode selected
	input  wire [1:0] port_off,       // Ports 2,1 disabled
	input  wire [7:0] remap_table,    // Logical number of port 1 [1:0], 2 [5:4]
	output reg  [1:0] port_active,    // Ports 2,1 enabled
	output reg  [1:0] port_count,     // Count of enabled ports
	output reg  [1:0] port1_number,   // Number reported for port 1, 0 off
	output reg  [1:0] port2_number    // Number reported for port 2, 0 off
);
	// Contiguous or table driven numbering
	always @*
	begin
		port_active = ~port_off;
		port_count  = {1'b0, port_active[0]} + {1'b0, port_active[1]};
		if (remap_mode)
		begin
			port1_number = remap_table[1:0];
			port2_number = remap_table[5:4];
			port_active  = {|remap_table[5:4], |remap_table[1:0]};
			port_count   = {1'b0, port_active[0]} + {1'b0, port_active[1]};
		end
		else
		begin
			port1_number = port_active[0] ? 2'd1 : 2'd0;
			port2_number = port_active[1] ?
				(port_active[0] ? 2'd2 : 2'd1) : 2'd0;
		end
	end
endmodule // hpmc_port_numbering

//--- rtl/hpmc_port_map_config.v
// Port map configuration registers of a two-port hub, APB slave
// Overview of operation
// - Config byte three bit 3 selects numbering method, reset zero is standard.
// - Standard mode reports port n as n, renumbering past disabled ports.
// - Standard mode enables come from straps or port-disable registers, reset zero.
// - Remap select one takes numbering from the separate remap register.
// - Config byte three bit 0 enables string descriptors, default disabled.
// - Fixed-device register bits 1 and 2 mark ports non-removable, reset zero.
// - Hub reports which active ports carry non-removable devices.
// - Internal default takes fixed-device flags from two strap pins.
// - Self-powered standard mode disables ports set in self-power disable register.
// - Standard mode: any disable combination gives correct count and reordered active ports.
// - Self-power disable bit 1 is port 1, bit 2 port 2, reset zero.
// - Internal default takes disabled ports from two strap pins.
// - Bus-powered standard mode uses bus-power disable register, same layout.
`timescale 1ns/1ps
`include "hpmc_consts.vh"
module hpmc_port_map_config (
	input  wire        core_clk,            // 25 MHz clock
	input  wire        resetn,              // Async reset, active low
	input  wire        psel,                // APB select
	input  wire        penable,             // APB access phase
	input  wire        pwrite,              // APB write
	input  wire [11:0] paddr,               // APB byte address
	input  wire [31:0] pwdata,              // APB write data
	output wire        pready,              // APB ready, always one
	output reg  [31:0] prdata,              // APB read data
	output wire        pslverr,             // APB error on unmapped address
	input  wire        use_default_config,  // Internal default option
	input  wire        self_powered,        // Self-powered operation
	input  wire [1:0]  fixed_device_straps, // Strap: ports 2,1 non-removable
	input  wire [1:0]  port_off_straps,     // Strap: ports 2,1 disabled
	output reg         string_enable,       // String descriptors on
	output reg  [1:0]  port_active,         // Ports 2,1 enabled
	output reg  [1:0]  port_count,          // Enabled port count to host
	output reg  [1:0]  port1_number,        // Host number of port 1
	output reg  [1:0]  port2_number,        // Host number of port 2
	output reg  [1:0]  fixed_device_ports   // Active non-removable ports 2,1
);
	reg  [7:0] cbt_r;
	reg  [7:0] fixed_r;
	reg  [7:0] sp_off_r;
	reg  [7:0] bp_off_r;
	reg  [7:0] remap_r;
	wire       wr_en;
	wire       rd_en;
	reg        addr_ok;
	wire       remap_mode;
	reg  [1:0] port_off;
	wire [1:0] fixed_sel;
	wire [1:0] act_w;
	wire [1:0] cnt_w;
	wire [1:0] num1_w;
	wire [1:0] num2_w;

	// Address decode
	always @*
	begin
		if (paddr == `HPMC_OFF_CBT)
			addr_ok = 1'b1;
		else if (paddr == `HPMC_OFF_FIXED)
			addr_ok = 1'b1;
		else if (paddr == `HPMC_OFF_SP_OFF)
			addr_ok = 1'b1;
		else if (paddr == `HPMC_OFF_BP_OFF)
			addr_ok = 1'b1;
		else if (paddr == `HPMC_OFF_REMAP)
			addr_ok = 1'b1;
		else if (paddr == `HPMC_OFF_STATUS)
			addr_ok = 1'b1;
		else
			addr_ok = 1'b0;
	end

	// Zero-wait APB handshake
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;
	assign wr_en   = psel & penable & pwrite & addr_ok;
	assign rd_en   = psel & ~penable & ~pwrite;

	// Register writes, reserved bits masked
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cbt_r    <= `HPMC_CBT_RST;
			fixed_r  <= `HPMC_FIXED_RST;
			sp_off_r <= `HPMC_SP_OFF_RST;
			bp_off_r <= `HPMC_BP_OFF_RST;
			remap_r  <= `HPMC_REMAP_RST;
		end
		else if (wr_en)
		begin
			if (paddr == `HPMC_OFF_CBT)
				cbt_r <= pwdata[7:0] & `HPMC_CBT_MASK;
			else if (paddr == `HPMC_OFF_FIXED)
				fixed_r <= pwdata[7:0] & `HPMC_PORT_MASK;
			else if (paddr == `HPMC_OFF_SP_OFF)
				sp_off_r <= pwdata[7:0] & `HPMC_PORT_MASK;
			else if (paddr == `HPMC_OFF_BP_OFF)
				bp_off_r <= pwdata[7:0] & `HPMC_PORT_MASK;
			else if (paddr == `HPMC_OFF_REMAP)
				remap_r <= pwdata[7:0];
		end
	end

	assign remap_mode = cbt_r[`HPMC_CBT_REMAP_BIT];

	// Disabled port source: straps, or register by power mode
	always @*
	begin
		if (use_default_config)
			port_off = port_off_straps;
		else if (self_powered)
			port_off = sp_off_r[2:1];
		else
			port_off = bp_off_r[2:1];
	end

	assign fixed_sel = use_default_config ? fixed_device_straps
		: fixed_r[2:1];

	// Numbering of enabled ports
	hpmc_port_numbering u_numbering (
		.remap_mode  (remap_mode),
		.port_off    (port_off),
		.remap_table (remap_r),
		.port_active (act_w),
		.port_count  (cnt_w),
		.port1_number(num1_w),
		.port2_number(num2_w)
	);

	// Registered host-facing view
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			string_enable      <= 1'b0;
			port_active        <= 2'b00;
			port_count         <= 2'b00;
			port1_number       <= 2'b00;
			port2_number       <= 2'b00;
			fixed_device_ports <= 2'b00;
		end
		else
		begin
			string_enable      <= cbt_r[`HPMC_CBT_STRING_BIT];
			port_active        <= act_w;
			port_count         <= cnt_w;
			port1_number       <= num1_w;
			port2_number       <= num2_w;
			fixed_device_ports <= fixed_sel & act_w;
		end
	end

	// Read data captured in setup cycle
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			prdata <= 32'h00000000;
		else if (rd_en)
		begin
			if (paddr == `HPMC_OFF_CBT)
				prdata <= {24'h000000, cbt_r};
			else if (paddr == `HPMC_OFF_FIXED)
				prdata <= {24'h000000, fixed_r};
			else if (paddr == `HPMC_OFF_SP_OFF)
				prdata <= {24'h000000, sp_off_r};
			else if (paddr == `HPMC_OFF_BP_OFF)
				prdata <= {24'h000000, bp_off_r};
			else if (paddr == `HPMC_OFF_REMAP)
				prdata <= {24'h000000, remap_r};
			else if (paddr == `HPMC_OFF_STATUS)
				prdata <= {22'h000000, fixed_device_ports,
					port_count, port2_number, port1_number,
					port_active};
			else
				prdata <= 32'h00000000;
		end
	end
endmodule // hpmc_port_map_config

//--- sim/hpmc_host_model.sv
// Host side view of the enumerated hub
`timescale 1ns/1ps
module hpmc_host_model (
	input  wire       core_clk,           // Clock
	input  wire [1:0] port_count,         // Ports offered
	input  wire [1:0] fixed_device_ports, // Fixed ports
	output reg  [1:0] host_ports_r        // Ports seen
);
	// Enumerate count only; fixed devices answer for themselves
	always @(posedge core_clk) host_ports_r <= port_count;
endmodule // hpmc_host_model

//--- sim/hpmc_sva.sv
// Assertions on the port map block ports
`timescale 1ns/1ps
module hpmc_sva (
	input wire        core_clk,      // Clock
	input wire        resetn,        // Reset
	input wire        psel,          // Select
	input wire        penable,       // Access
	input wire        pwrite,        // Write
	input wire [11:0] paddr,         // Address
	input wire [31:0] pwdata,        // Wdata
	input wire        pready,        // Ready
	input wire [31:0] prdata,        // Rdata
	input wire        pslverr,       // Error
	input wire        string_enable, // Strings
	input wire [1:0]  port_active,   // Active
	input wire [1:0]  port_count,    // Count
	input wire [1:0]  port1_number,  // Port 1
	input wire [1:0]  port2_number,  // Port 2
	input wire [1:0]  fixed_device_ports // Fixed
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	reg wb_r;
	wire acc = psel && penable;
	wire bad = !(paddr inside {12'h020, 12'h024, 12'h028, 12'h02C,
		12'h3EC, 12'h040});
	// Last string bit written to config byte three
	always @(posedge core_clk)
		if (acc && pwrite && paddr == 12'h020)
			wb_r <= pwdata[0];
	property p_cnt; port_count == $countones(port_active); endproperty
	a_cnt: assert property (p_cnt) else $error("count off");
	property p_fix; (fixed_device_ports & ~port_active) == 2'h0; endproperty
	a_fix: assert property (p_fix) else $error("fixed off");
	property p_rdy; acc |-> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready");
	property p_str;
		acc && pwrite && paddr == 12'h020 |-> ##[1:2] string_enable == wb_r;
	endproperty
	a_str: assert property (p_str) else $error("string off");
	property p_err; acc && bad |-> pslverr; endproperty
	a_err: assert property (p_err) else $error("no error");
	property p_rd; acc && !pwrite && bad |-> prdata == 32'h0; endproperty
	a_rd: assert property (p_rd) else $error("bad read");
	property p_n1; (port1_number == 2'h0) == !port_active[0]; endproperty
	a_n1: assert property (p_n1) else $error("port1 off");
	property p_n2; (port2_number == 2'h0) == !port_active[1]; endproperty
	a_n2: assert property (p_n2) else $error("port2 off");
	c_one: cover property (port_count == 2'h1);
	c_err: cover property (acc && bad);
	c_fix: cover property (fixed_device_ports != 2'h0);
endmodule // hpmc_sva
bind hpmc_port_map_config hpmc_sva u_sva (.core_clk, .resetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
	.string_enable, .port_active, .port_count, .port1_number,
	.port2_number, .fixed_device_ports);

//--- sim/test_hub_port_map_config.sv
// Random register and port numbering bench
`timescale 1ns/1ps
module test_hub_port_map_config;
	reg core_clk, resetn, psel, penable, pwrite, dflt, spw;
	reg [11:0] paddr;
	reg [31:0] pwdata, rd, d;
	reg [10:0] e;
	wire [1:0] hp;
	reg [1:0] fs, ps;
	reg er;
	wire pready, pslverr, se;
	wire [31:0] prdata;
	wire [1:0] pa, pc, n1, n2, fx;
	reg [7:0] m [0:5];
	reg [11:0] ad [0:5] = '{12'h020, 12'h024, 12'h028, 12'h02C, 12'h3EC,
		12'h100};
	reg [7:0] mk [0:5] = '{8'h09, 8'h06, 8'h06, 8'h06, 8'hFF, 8'h00};
	integer n_mismatch = 0, num_checks = 0, i, k;
	hpmc_port_map_config u_hpmc_port_map_config (.core_clk, .resetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.use_default_config(dflt), .self_powered(spw),
		.fixed_device_straps(fs), .port_off_straps(ps), .string_enable(se),
		.port_active(pa), .port_count(pc), .port1_number(n1),
		.port2_number(n2), .fixed_device_ports(fx));
	hpmc_host_model u_hpmc_host_model (.core_clk, .port_count(pc),
		.fixed_device_ports(fx), .host_ports_r(hp));
	// Expected host view from the register model
	function [10:0] expv;
		reg [1:0] a, p, q;
		begin
			if (m[0][3])
				begin
					p = m[4][1:0];
					q = m[4][5:4];
					a = {|q, |p};
				end
			else
				begin
					a = ~(dflt ? ps : (spw ? m[2][2:1] : m[3][2:1]));
					p = {1'b0, a[0]};
					q = a[1] ? {a[0], ~a[0]} : 2'h0;
				end
			expv = {m[0][0], a, a[0] & a[1], a[0] ^ a[1], p, q,
				(dflt ? fs : m[1][2:1]) & a};
		end
	endfunction
	task complete_run;
		begin
			$display("checks %0d mismatches %0d", num_checks, n_mismatch);
			if (n_mismatch == 0 && num_checks > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	task chk(input [31:0] s, input [31:0] e);
		begin
			num_checks++;
			if (s !== e)
				begin
					n_mismatch++;
					$display("mismatch at %0t: seen %h expected %h", $time, s, e);
				end
		end
	endtask
	// One APB transfer, held until ready
	task apb(input w, input [11:0] a, input [31:0] wd);
		integer t;
		begin
			@(posedge core_clk);
			{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
			@(posedge core_clk);
			penable <= 1;
			t = 0;
			do begin @(posedge core_clk); t++; end while (pready !== 1'b1 && t < 50);
			if (t >= 50)
				begin
					n_mismatch++;
					complete_run;
				end
			rd = prdata;
			er = pslverr;
			{psel, penable} <= 2'b00;
		end
	endtask
	// Clock
	initial
	begin
		core_clk = 0;
		forever #20 core_clk = ~core_clk;
	end
	// Reset values, then random writes and readback
	initial
	begin
		{resetn, psel, penable, pwrite, dflt, spw, paddr, pwdata, fs, ps} = 0;
		d = $urandom(32'h97DF);
		m = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h21, 8'h00};
		repeat (4) @(posedge core_clk);
		resetn <= 1;
		@(posedge core_clk);
		@(negedge core_clk);
		chk({pc, n1, n2}, 6'h26);
		for (i = 0; i < 6; i++)
			begin
				apb(0, ad[i], 0);
				chk(rd, m[i]);
			end
		repeat (80)
			begin
				k = $urandom % 6;
				d = $urandom;
				@(posedge core_clk);
				{dflt, spw, fs, ps} <= $urandom;
				apb(1, ad[k], d);
				m[k] = d[7:0] & mk[k];
				chk(er, k == 5);
				repeat (2) @(posedge core_clk);
				@(negedge core_clk);
				e = expv();
				chk({se, pa, pc, n1, n2, fx}, e);
				chk(hp, e[7:6]);
				apb(0, 12'h040, 0);
				chk(rd, {e[1:0], e[7:6], e[3:2], e[5:4], e[9:8]});
				apb(0, ad[k], 0);
				chk(rd, m[k]);
			end
		complete_run;
	end
endmodule // test_hub_port_map_config
